// file: rtl/cfg_bridge_dev.sv
// Design decisions made here: register access over the local link and the register offsets.
`timescale 1ns/1ps
module cfg_bridge_dev
  import cfg_bridge_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  lb_link_if.dev lb,
  input wire logic i_lb_owner, // Local side owns the register channel
  output logic o_own_req, // Ownership request toward arbiter
  output logic o_cfg_req, // PCI cycle wanted, held until done
  output logic [3:0] o_cfg_cmd,
  output logic [31:0] o_cfg_addr,
  output logic [3:0] o_cfg_cbe_n,
  output logic [31:0] o_cfg_wdata,
  input wire logic i_cfg_done, // One-cycle completion pulse
  input wire logic i_cfg_mabort, // Valid with done
  input wire logic [31:0] i_cfg_rdata, // Valid with done
  input wire logic i_pci_mb_wr, // PCI write to a mailbox
  input wire logic [1:0] i_pci_mb_sel,
  input wire logic [3:0] i_pci_be_n,
  input wire logic [31:0] i_pci_wdata,
  input wire logic [3:0] i_pci_stat_clr, // PCI write-one-to-clear pulses
  output logic [31:0] o_pci_mb_rdata,
  output logic o_pci_int_n
);

  // Whole module state
  typedef struct packed {
    logic clk_s1, clk_s2, clk_d;
    logic cs_s1, cs_s2;
    logic we_s1, we_s2;
    logic [11:0] addr_s1, addr_s2;
    logic [1:0] size_s1, size_s2;
    logic [31:0] wd_s1, wd_s2;
    logic busy; // A response is on the link
    logic ack, retry, err;
    logic [31:0] rdata;
    logic [31:0] cfg_addr;
    logic [31:0] cfg_data;
    logic bme, mas;
    logic [3:0] irq_en, irq_dir, irq_stat;
    logic [3:0][31:0] mb;
    logic [31:0] pci_rdata;
    tr_e tr;
    logic [11:0] tr_addr; // Local address of the pending access
    logic [1:0] tr_size;
    logic tr_we;
    logic tr_mabort;
    logic req;
    logic [3:0] cmd;
    logic [31:0] paddr;
    logic [3:0] cbe_n;
    logic [31:0] pwdata;
    logic own_req;
    logic lint, pint;
  } dev_state_s;

  dev_state_s s_r, s_nxt;

  // Active-high byte mask from address low bits and size
  function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic [1:0] sz);
    logic [3:0] m;
    m = 4'hF;
    case (sz)
      SIZE_BYTE: m = 4'(4'h1 << a);
      SIZE_HALF: m = a[1] ? 4'hC : 4'h3;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // Merge write data into a word under a byte mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (m[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  logic ev; // Link rising edge with a fresh request
  logic [3:0] wmask;
  logic [9:0] widx;
  logic [3:0] mb_pci_set, mb_lb_set, stat_clr;
  logic [31:0] cfg_phase_addr;

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    // Synchronisers: first stage is read only by the second
    s_nxt.clk_s1 = lb.lb_clk;
    s_nxt.clk_s2 = s_r.clk_s1;
    s_nxt.clk_d = s_r.clk_s2;
    s_nxt.cs_s1 = lb.lb_cs;
    s_nxt.cs_s2 = s_r.cs_s1;
    s_nxt.we_s1 = lb.lb_we;
    s_nxt.we_s2 = s_r.we_s1;
    s_nxt.addr_s1 = lb.lb_addr;
    s_nxt.addr_s2 = s_r.addr_s1;
    s_nxt.size_s1 = lb.lb_size;
    s_nxt.size_s2 = s_r.size_s1;
    s_nxt.wd_s1 = lb.lb_wdata;
    s_nxt.wd_s2 = s_r.wd_s1;

    ev = s_r.clk_s2 & ~s_r.clk_d & s_r.cs_s2 & ~s_r.busy;
    wmask = lane_mask(s_r.addr_s2[1:0], s_r.size_s2);
    widx = s_r.addr_s2[11:2];
    mb_pci_set = '0;
    mb_lb_set = '0;
    stat_clr = i_pci_stat_clr;

    // Address phase: type 1 passes the word, type 0 decodes device
    if (s_r.cfg_addr[CA_TYPE_BIT]) begin
      cfg_phase_addr = s_r.cfg_addr;
    end else begin
      cfg_phase_addr = {16'(16'h0001 << s_r.cfg_addr[CA_DEV_LSB +: 4]),
                        5'h00, s_r.cfg_addr[CA_FUNC_LSB +: 3],
                        s_r.cfg_addr[CA_REG_LSB +: 6], 2'h0};
    end

    // Response is withdrawn once the host lets go of select
    if (s_r.busy && !s_r.cs_s2) begin
      s_nxt.busy = 1'b0;
      s_nxt.ack = 1'b0;
      s_nxt.retry = 1'b0;
      s_nxt.err = 1'b0;
    end

    // PCI side completion of the outstanding cycle
    if (s_r.tr == TR_PEND && i_cfg_done) begin
      s_nxt.req = 1'b0;
      s_nxt.tr = TR_DONE;
      s_nxt.tr_mabort = i_cfg_mabort;
      if (!s_r.tr_we) begin
        // Aborted reads return all ones
        s_nxt.cfg_data = i_cfg_mabort ? 32'hFFFF_FFFF : i_cfg_rdata;
      end
    end

    // Ownership request drops once granted
    if (i_lb_owner) begin
      s_nxt.own_req = 1'b0;
    end

    // Local bus access
    if (ev) begin
      s_nxt.busy = 1'b1;
      s_nxt.rdata = '0;
      if (!i_lb_owner) begin
        s_nxt.retry = 1'b1;
        s_nxt.own_req = 1'b1;
      end else if (widx == OFS_CFG_DATA[11:2] || (widx == OFS_INTACK[11:2] && !s_r.we_s2)) begin
        case (s_r.tr)
          TR_IDLE: begin
            if (!s_r.bme) begin
              // Bus mastering off: refuse instead of hanging the master
              s_nxt.ack = 1'b1;
              s_nxt.err = 1'b1;
            end else begin
              s_nxt.retry = 1'b1;
              s_nxt.tr = TR_PEND;
              s_nxt.req = 1'b1;
              s_nxt.tr_addr = s_r.addr_s2;
              s_nxt.tr_size = s_r.size_s2;
              s_nxt.tr_we = s_r.we_s2;
              s_nxt.cbe_n = ~wmask;
              s_nxt.pwdata = s_r.wd_s2;
              if (widx == OFS_INTACK[11:2]) begin
                s_nxt.cmd = PCI_CMD_INTACK;
                s_nxt.paddr = '0;
              end else begin
                s_nxt.cmd = s_r.we_s2 ? PCI_CMD_CFG_WRITE : PCI_CMD_CFG_READ;
                s_nxt.paddr = cfg_phase_addr;
              end
            end
          end
          TR_DONE: begin
            if (s_r.addr_s2 == s_r.tr_addr && s_r.we_s2 == s_r.tr_we && s_r.size_s2 == s_r.tr_size) begin
              // Same access came back: finish it
              s_nxt.ack = 1'b1;
              s_nxt.err = s_r.tr_mabort & ~s_r.mas;
              s_nxt.rdata = s_r.tr_we ? '0 : s_r.cfg_data;
              if (s_r.tr_we) begin
                s_nxt.cfg_data = merge(s_r.cfg_data, s_r.pwdata, ~s_r.cbe_n);
              end
              s_nxt.tr = TR_IDLE;
            end else begin
              s_nxt.retry = 1'b1;
            end
          end
          default: s_nxt.retry = 1'b1; // Outstanding: retry every data-port access and INTACK read
        endcase
      end else begin
        s_nxt.ack = 1'b1;
        // Plain registers, one word each
        if (widx == OFS_CFG_TARGET_ADDR[11:2]) begin
          if (s_r.we_s2) begin
            s_nxt.cfg_addr = merge(s_r.cfg_addr, s_r.wd_s2, wmask);
          end
          s_nxt.rdata = s_r.cfg_addr;
        end else if (widx == OFS_MISC_CONTROL[11:2]) begin
          if (s_r.we_s2 && wmask[0]) begin
            s_nxt.bme = s_r.wd_s2[MC_BUS_MASTER_ENABLE_BIT];
            s_nxt.mas = s_r.wd_s2[MC_MASTER_ABORT_SUCCESS_BIT];
          end
          s_nxt.rdata[MC_BUS_MASTER_ENABLE_BIT] = s_r.bme;
          s_nxt.rdata[MC_MASTER_ABORT_SUCCESS_BIT] = s_r.mas;
        end else if (widx == OFS_INTERRUPT_CONTROL[11:2]) begin
          if (s_r.we_s2 && wmask[0]) begin
            s_nxt.irq_en = s_r.wd_s2[3:0];
          end
          s_nxt.rdata[3:0] = s_r.irq_en;
        end else if (widx == OFS_INTERRUPT_DIRECTION[11:2]) begin
          if (s_r.we_s2 && wmask[0]) begin
            s_nxt.irq_dir = s_r.wd_s2[3:0];
          end
          s_nxt.rdata[3:0] = s_r.irq_dir;
        end else if (widx == OFS_INTERRUPT_STATUS[11:2]) begin
          if (s_r.we_s2 && wmask[0]) begin
            stat_clr = stat_clr | s_r.wd_s2[3:0];
          end
          s_nxt.rdata[3:0] = s_r.irq_stat;
        end else if (widx[9:2] == OFS_MAILBOX0[11:4]) begin
          if (s_r.we_s2) begin
            s_nxt.mb[widx[1:0]] = merge(s_r.mb[widx[1:0]], s_r.wd_s2, wmask);
            mb_lb_set[widx[1:0]] = |wmask;
          end
          s_nxt.rdata = s_r.mb[widx[1:0]];
        end
        // Unmapped words acknowledge and read zero
      end
    end

    // PCI mailbox write, only while PCI holds the channel
    if (i_pci_mb_wr && !i_lb_owner) begin
      s_nxt.mb[i_pci_mb_sel] = merge(s_nxt.mb[i_pci_mb_sel], i_pci_wdata, ~i_pci_be_n);
      mb_pci_set[i_pci_mb_sel] = |(~i_pci_be_n);
    end
    s_nxt.pci_rdata = s_r.mb[i_pci_mb_sel];

    // Status: set beats clear; only writes from the far side count
    for (int i = 0; i < 4; i++) begin
      if ((mb_pci_set[i] && s_r.irq_en[i] && !s_r.irq_dir[i]) ||
          (mb_lb_set[i] && s_r.irq_en[i] && s_r.irq_dir[i])) begin
        s_nxt.irq_stat[i] = 1'b1;
      end else if (stat_clr[i]) begin
        s_nxt.irq_stat[i] = 1'b0;
      end
    end
    s_nxt.lint = |(s_r.irq_stat & s_r.irq_en & ~s_r.irq_dir);
    s_nxt.pint = |(s_r.irq_stat & s_r.irq_en & s_r.irq_dir);
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
      s_r.cfg_addr <= RST_CFG_TARGET_ADDR;
      s_r.mb <= {4{RST_MAILBOX}};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign lb.lb_rdata = s_r.rdata;
  assign lb.lb_ack = s_r.ack;
  assign lb.lb_retry = s_r.retry;
  assign lb.lb_err = s_r.err;
  assign lb.int_oe = s_r.lint;
  assign o_own_req = s_r.own_req;
  assign o_cfg_req = s_r.req;
  assign o_cfg_cmd = s_r.cmd;
  assign o_cfg_addr = s_r.paddr;
  assign o_cfg_cbe_n = s_r.cbe_n;
  assign o_cfg_wdata = s_r.pwdata;
  assign o_pci_mb_rdata = s_r.pci_rdata;
  assign o_pci_int_n = ~s_r.pint;

endmodule // cfg_bridge_dev

// file: rtl/cfg_bridge_pkg.sv
package cfg_bridge_pkg;
  // Core clock and local link clock timing
  localparam int CORE_CLK_PERIOD_NS = 50;
  localparam int LB_CLK_PERIOD_NS = 400;
  // Core cycles per half period of the link clock the host makes
  localparam int LB_HALF_CYCLES = LB_CLK_PERIOD_NS / (2 * CORE_CLK_PERIOD_NS);

  // Device register offsets on the local processor bus
  localparam logic [11:0] OFS_CFG_TARGET_ADDR = 12'h000;
  localparam logic [11:0] OFS_CFG_DATA = 12'h004;
  localparam logic [11:0] OFS_MISC_CONTROL = 12'h008;
  localparam logic [11:0] OFS_INTERRUPT_CONTROL = 12'h00C;
  localparam logic [11:0] OFS_INTERRUPT_DIRECTION = 12'h010;
  localparam logic [11:0] OFS_INTERRUPT_STATUS = 12'h014;
  localparam logic [11:0] OFS_INTACK = 12'h018;
  localparam logic [11:0] OFS_MAILBOX0 = 12'h020;

  // Target address register fields
  localparam int CA_TYPE_BIT = 0;
  localparam int CA_REG_LSB = 2;
  localparam int CA_FUNC_LSB = 8;
  localparam int CA_DEV_LSB = 11;
  // Misc control fields
  localparam int MC_BUS_MASTER_ENABLE_BIT = 0;
  localparam int MC_MASTER_ABORT_SUCCESS_BIT = 1;

  // Reset values
  localparam logic [31:0] RST_CFG_TARGET_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_MAILBOX = 32'h0000_0000;

  // PCI bus commands issued by the configuration engine
  localparam logic [3:0] PCI_CMD_INTACK = 4'h0;
  localparam logic [3:0] PCI_CMD_CFG_READ = 4'hA;
  localparam logic [3:0] PCI_CMD_CFG_WRITE = 4'hB;

  // Transfer size codes on the local bus
  localparam logic [1:0] SIZE_WORD = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_HALF = 2'h2;

  // Host controller APB register offsets
  localparam logic [7:0] HC_OFS_CMD = 8'h00;
  localparam logic [7:0] HC_OFS_ADDR = 8'h04;
  localparam logic [7:0] HC_OFS_WDATA = 8'h08;
  localparam logic [7:0] HC_OFS_RDATA = 8'h0C;
  localparam logic [7:0] HC_OFS_STATUS = 8'h10;
  localparam int HC_CMD_START_BIT = 0;
  localparam int HC_CMD_WRITE_BIT = 1;
  localparam int HC_CMD_SIZE_LSB = 2;

  // Delayed transaction state
  typedef enum logic [1:0] {
    TR_IDLE = 2'b00,
    TR_PEND = 2'b01,
    TR_DONE = 2'b10
  } tr_e;

  // Host link sequencer state
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_REQ = 2'b01,
    H_REL = 2'b10
  } host_e;
endpackage

// file: rtl/lb_host_ctrl.sv
`timescale 1ns/1ps
module lb_host_ctrl
  import cfg_bridge_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  lb_link_if.host lb
);

  // Whole module state
  typedef struct packed {
    logic [7:0] div; // Half-period divider
    logic lclk;
    host_e st;
    logic pend, again;
    logic cs, we;
    logic [11:0] addr;
    logic [1:0] size;
    logic [31:0] wdata, rdata;
    // Link-side copies, moved only as the link clock falls
    logic [11:0] laddr;
    logic lwe;
    logic [1:0] lsize;
    logic [31:0] lwdata;
    logic done, err;
    logic ack_s1, ack_s2, rty_s1, rty_s2, err_s1, err_s2, int_s1, int_s2;
    logic [31:0] rd_s1, rd_s2;
    logic [31:0] prdata;
    logic pslverr;
  } host_state_s;

  host_state_s s_r, s_nxt;
  logic tick, fall, setup, wr;

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    // Response synchronisers
    s_nxt.ack_s1 = lb.lb_ack;
    s_nxt.ack_s2 = s_r.ack_s1;
    s_nxt.rty_s1 = lb.lb_retry;
    s_nxt.rty_s2 = s_r.rty_s1;
    s_nxt.err_s1 = lb.lb_err;
    s_nxt.err_s2 = s_r.err_s1;
    s_nxt.int_s1 = lb.int_n;
    s_nxt.int_s2 = s_r.int_s1;
    s_nxt.rd_s1 = lb.lb_rdata;
    s_nxt.rd_s2 = s_r.rd_s1;

    // Link clock divider; request changes only as the clock falls
    tick = (s_r.div == 8'(LB_HALF_CYCLES - 1));
    s_nxt.div = tick ? 8'h00 : 8'(s_r.div + 8'h01);
    if (tick) begin
      s_nxt.lclk = ~s_r.lclk;
    end
    fall = tick & s_r.lclk;

    // APB register access, answered without wait states
    setup = i_psel & ~i_penable;
    // Write lands in the access phase, where pready is sampled
    wr = i_psel & i_penable & i_pwrite;
    if (setup) begin
      s_nxt.prdata = '0;
      s_nxt.pslverr = 1'b0;
      case (i_paddr)
        HC_OFS_CMD: s_nxt.prdata = {28'h0, s_r.size, s_r.we, 1'b0};
        HC_OFS_ADDR: s_nxt.prdata = {20'h0, s_r.addr};
        HC_OFS_WDATA: s_nxt.prdata = s_r.wdata;
        HC_OFS_RDATA: s_nxt.prdata = s_r.rdata;
        HC_OFS_STATUS: s_nxt.prdata = {28'h0, ~s_r.int_s2, s_r.err, s_r.done, s_r.pend};
        default: s_nxt.pslverr = 1'b1; // Unmapped offset
      endcase
    end
    // Settings are frozen while a transfer runs
    if (wr && !s_r.pend) begin
      case (i_paddr)
        HC_OFS_CMD: begin
          s_nxt.we = i_pwdata[HC_CMD_WRITE_BIT];
          s_nxt.size = i_pwdata[HC_CMD_SIZE_LSB +: 2];
          if (i_pwdata[HC_CMD_START_BIT]) begin
            s_nxt.pend = 1'b1;
            s_nxt.done = 1'b0;
            s_nxt.err = 1'b0;
          end
        end
        HC_OFS_ADDR: s_nxt.addr = i_pwdata[11:0]; // Target address before data access
        HC_OFS_WDATA: s_nxt.wdata = i_pwdata;
        default: ;
      endcase
    end

    // Link sequencer: repeats a retried access until it ends
    case (s_r.st)
      H_IDLE: begin
        if (s_r.pend && fall) begin
          s_nxt.cs = 1'b1;
          // Settings reach the link only here, never mid-period
          s_nxt.laddr = s_r.addr;
          s_nxt.lwe = s_r.we;
          s_nxt.lsize = s_r.size;
          s_nxt.lwdata = s_r.wdata;
          s_nxt.st = H_REQ;
        end
      end
      H_REQ: begin
        if ((s_r.ack_s2 || s_r.rty_s2) && fall) begin
          s_nxt.cs = 1'b0;
          s_nxt.again = s_r.rty_s2; // Delayed transaction: come back
          if (s_r.ack_s2) begin
            s_nxt.rdata = s_r.rd_s2;
            s_nxt.err = s_r.err_s2;
          end
          s_nxt.st = H_REL;
        end
      end
      H_REL: begin
        if (!s_r.ack_s2 && !s_r.rty_s2) begin
          s_nxt.st = H_IDLE;
          if (!s_r.again) begin
            s_nxt.pend = 1'b0;
            s_nxt.done = 1'b1;
          end
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_r <= '0;
      s_r.int_s1 <= 1'b1;
      s_r.int_s2 <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign o_prdata = s_r.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = s_r.pslverr;
  assign lb.lb_clk = s_r.lclk;
  assign lb.lb_cs = s_r.cs;
  assign lb.lb_we = s_r.lwe;
  assign lb.lb_addr = s_r.laddr;
  assign lb.lb_size = s_r.lsize;
  assign lb.lb_wdata = s_r.lwdata;

endmodule // lb_host_ctrl

// file: rtl/lb_link_if.sv
`timescale 1ns/1ps
interface lb_link_if;
  logic lb_clk; // Link clock, made by the host
  logic lb_cs; // Register select, level
  logic lb_we; // Write when high
  logic [11:0] lb_addr; // Byte address
  logic [1:0] lb_size; // Transfer size
  logic [31:0] lb_wdata; // Write data
  logic [31:0] lb_rdata; // Read data
  logic lb_ack; // Normal end, with or without error
  logic lb_retry; // Retry, come back later
  logic lb_err; // Error end
  logic int_oe; // Device pulls interrupt low
  logic int_n; // Resolved open-drain interrupt level

  // Open drain: low while the device drives, else pulled high
  assign int_n = int_oe ? 1'b0 : 1'b1;

  modport dev (input lb_clk, lb_cs, lb_we, lb_addr, lb_size, lb_wdata,
               output lb_rdata, lb_ack, lb_retry, lb_err, int_oe);
  modport host (output lb_clk, lb_cs, lb_we, lb_addr, lb_size, lb_wdata,
                input lb_rdata, lb_ack, lb_retry, lb_err, int_n);
endinterface

// file: sim/cfg_bridge_chk.sv
`timescale 1ns/1ps
module cfg_bridge_chk (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic lb_clk,
  input wire logic lb_cs,
  input wire logic lb_we,
  input wire logic [11:0] lb_addr,
  input wire logic lb_ack,
  input wire logic lb_retry,
  input wire logic lb_err,
  input wire logic int_n
);
  // One domain, so one clocking and one disable
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  // Any end of a link cycle
  wire logic resp = lb_ack | lb_retry;
  // A cycle ends one way only
  chk_end_exclusive: assert property (!(lb_ack && lb_retry)) else $error("ack and retry together");
  chk_err_ack: assert property (lb_err |-> lb_ack) else $error("error end without ack");
  chk_resp_cs: assert property ($rose(resp) |-> lb_cs) else $error("response without request");
  // Response stands while the request is still up
  chk_resp_stands: assert property (resp && lb_cs |=> $stable({lb_ack, lb_retry, lb_err}))
    else $error("response changed under request");
  chk_resp_drop: assert property ($fell(lb_cs) |-> ##[1:5] !resp) else $error("response not dropped");
  // Host holds its request until answered
  chk_req_hold: assert property (lb_cs && !resp |=> lb_cs && $stable(lb_addr) && $stable(lb_we))
    else $error("request changed before answer");
  chk_req_low: assert property ($changed(lb_addr) |-> !lb_clk) else $error("address moved while clock high");
  // Divider gives four core cycles per half period
  chk_clk_half: assert property ($rose(lb_clk) |-> lb_clk[*4] ##1 !lb_clk) else $error("link clock half period");
  // Every sampled request gets ack or retry soon
  chk_resp_soon: assert property ($rose(lb_clk) && lb_cs && !resp |-> ##[1:8] resp)
    else $error("no response to request");
  cover property ($rose(lb_retry));
  cover property (lb_ack && lb_err);
  cover property ($fell(int_n));
endmodule // cfg_bridge_chk

// file: sim/config_cycle_gen_and_mailboxes_test.sv
`timescale 1ns/1ps
module config_cycle_gen_and_mailboxes_test;
  import cfg_bridge_pkg::*;
  // One ordinary config case
  typedef struct {logic [31:0] ta; logic w; logic [1:0] sz; logic [1:0] lo; logic [31:0] ea; logic [3:0] cbe;} row_s;
  logic i_core_clk, i_nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic lb_owner, own_req, cfg_req, cfg_done, cfg_mabort, pci_mb_wr, pci_int_n;
  logic [3:0] cfg_cmd, cfg_cbe_n, pci_be_n, pci_stat_clr;
  logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, pci_wdata, pci_mb_rdata;
  logic [1:0] pci_mb_sel;
  int err_total = 0;
  int total_checks = 0;
  int retries = 0;
  // Type 0 corners, type 1, and byte lanes of each size
  row_s rows [6] = '{'{32'h0, 1'b0, SIZE_WORD, 2'h0, 32'h0001_0000, 4'h0},
    '{32'h7FFC, 1'b0, SIZE_WORD, 2'h0, 32'h8000_07FC, 4'h0},
    '{32'h00AB_CD01, 1'b0, SIZE_WORD, 2'h0, 32'h00AB_CD01, 4'h0},
    '{32'h1A14, 1'b1, SIZE_BYTE, 2'h3, 32'h0008_0214, 4'h7},
    '{32'h4804, 1'b1, SIZE_HALF, 2'h2, 32'h0200_0004, 4'h3},
    '{32'h8765_4321, 1'b1, SIZE_HALF, 2'h0, 32'h8765_4321, 4'hC}};
  lb_link_if link();
  lb_host_ctrl lb_host_ctrl_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .lb(link.host));
  cfg_bridge_dev cfg_bridge_dev_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .lb(link.dev), .i_lb_owner(lb_owner),
    .o_own_req(own_req), .o_cfg_req(cfg_req), .o_cfg_cmd(cfg_cmd), .o_cfg_addr(cfg_addr), .o_cfg_cbe_n(cfg_cbe_n),
    .o_cfg_wdata(cfg_wdata), .i_cfg_done(cfg_done), .i_cfg_mabort(cfg_mabort), .i_cfg_rdata(cfg_rdata),
    .i_pci_mb_wr(pci_mb_wr), .i_pci_mb_sel(pci_mb_sel), .i_pci_be_n(pci_be_n), .i_pci_wdata(pci_wdata),
    .i_pci_stat_clr(pci_stat_clr), .o_pci_mb_rdata(pci_mb_rdata), .o_pci_int_n(pci_int_n));
  cfg_bridge_chk cfg_bridge_chk_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .lb_clk(link.lb_clk),
    .lb_cs(link.lb_cs), .lb_we(link.lb_we), .lb_addr(link.lb_addr), .lb_ack(link.lb_ack),
    .lb_retry(link.lb_retry), .lb_err(link.lb_err), .int_n(link.int_n));
  // Core clock, 50 ns
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // Counts retries seen on the link
  always @(posedge link.lb_retry) retries++;
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; no fixed latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do @(posedge i_core_clk); while (pready !== 1'b1);
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lnk_start(input logic w, input logic [1:0] sz, input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, HC_OFS_ADDR, {20'h0, a});
    apb(1'b1, HC_OFS_WDATA, d);
    apb(1'b1, HC_OFS_CMD, {28'h0, sz, w, 1'b1});
  endtask
  // Host re-issues retries itself; wait for idle
  task automatic lnk_wait();
    do apb(1'b0, HC_OFS_STATUS, 32'h0); while (st[0] !== 1'b0);
    rd = st;
    apb(1'b0, HC_OFS_RDATA, 32'h0);
    // Status back into st, read data into rd
    {st, rd} = {rd, st};
  endtask
  task automatic lnk(input logic w, input logic [11:0] a, input logic [31:0] d);
    lnk_start(w, SIZE_WORD, a, d);
    lnk_wait();
  endtask
  task automatic wait_req();
    while (cfg_req !== 1'b1) @(posedge i_core_clk);
  endtask
  task automatic pulse_done(input logic [31:0] r, input logic m);
    @(posedge i_core_clk);
    cfg_done <= 1'b1;
    cfg_rdata <= r;
    cfg_mabort <= m;
    @(posedge i_core_clk);
    cfg_done <= 1'b0;
  endtask
  // Full delayed config transaction with outstanding checks
  task automatic cfg(input row_s r, input logic [31:0] d);
    lnk(1'b1, OFS_CFG_TARGET_ADDR, r.ta);
    retries = 0;
    lnk_start(r.w, r.sz, OFS_CFG_DATA | {10'h0, r.lo}, d);
    wait_req();
    repeat (80) @(posedge i_core_clk);
    chk_bit(cfg_req, 1'b1);
    chk_bit(retries > 1, 1'b1);
    chk_word({28'h0, cfg_cmd}, {28'h0, r.w ? PCI_CMD_CFG_WRITE : PCI_CMD_CFG_READ});
    chk_word(cfg_addr, r.ea);
    chk_word({28'h0, cfg_cbe_n}, {28'h0, r.cbe});
    if (r.w) chk_word(cfg_wdata, d);
    apb(1'b0, HC_OFS_STATUS, 32'h0);
    chk_bit(st[0], 1'b1);
    pulse_done(~d, 1'b0);
    lnk_wait();
    chk_bit(st[2], 1'b0);
    if (!r.w) chk_word(rd, ~d);
  endtask
  // Delayed read whose PCI end the bench chooses
  task automatic dly_rd(input logic [11:0] a, input logic [3:0] cmd, input logic [31:0] d, input logic m);
    lnk_start(1'b0, SIZE_WORD, a, 32'h0);
    wait_req();
    chk_word({28'h0, cfg_cmd}, {28'h0, cmd});
    pulse_done(d, m);
    lnk_wait();
  endtask
  task automatic pci_wr(input logic [1:0] s, input logic [3:0] be, input logic [31:0] d);
    @(posedge i_core_clk);
    pci_mb_wr <= 1'b1;
    pci_mb_sel <= s;
    pci_be_n <= be;
    pci_wdata <= d;
    @(posedge i_core_clk);
    pci_mb_wr <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask
  // Watchdog well beyond the expected run
  initial begin
    repeat (60000) @(posedge i_core_clk);
    err_total++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cfg_done, cfg_mabort, cfg_rdata, pci_mb_wr, pci_mb_sel, pci_wdata, pci_stat_clr} = '0;
    pci_be_n = 4'hF;
    lb_owner = 1'b1;
    i_nrst = 1'b0;
    repeat (12) @(posedge i_core_clk);
    chk_bit(link.int_n, 1'b1);
    chk_bit(pci_int_n, 1'b1);
    chk_bit(link.lb_cs, 1'b0);
    chk_bit(cfg_req, 1'b0);
    i_nrst <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    chk_bit(pslverr, 1'b1);
    // Bus master enable still off: error end, no PCI cycle
    lnk(1'b0, OFS_CFG_DATA, 32'h0);
    chk_bit(st[2], 1'b1);
    chk_bit(cfg_req, 1'b0);
    // Not owned: retried until ownership arrives
    lb_owner <= 1'b0;
    lnk_start(1'b1, SIZE_WORD, OFS_MISC_CONTROL, 32'h1);
    while (own_req !== 1'b1) @(posedge i_core_clk);
    chk_bit(link.lb_retry | (retries > 0), 1'b1);
    lb_owner <= 1'b1;
    lnk_wait();
    chk_bit(own_req, 1'b0);
    foreach (rows[i]) cfg(rows[i], 32'hC0DE_0000 + i);
    for (int n = 0; n < 16; n++) cfg('{n << 11, 1'b0, SIZE_WORD, 2'h0, 32'h1 << (16 + n), 4'h0}, 32'h0);
    dly_rd(OFS_CFG_DATA, PCI_CMD_CFG_READ, 32'h5, 1'b1);
    chk_bit(st[2], 1'b1);
    chk_word(rd, 32'hFFFF_FFFF);
    lnk(1'b1, OFS_MISC_CONTROL, 32'h3);
    dly_rd(OFS_CFG_DATA, PCI_CMD_CFG_READ, 32'h5, 1'b1);
    chk_bit(st[2], 1'b0);
    dly_rd(OFS_INTACK, PCI_CMD_INTACK, 32'hA5, 1'b0);
    chk_word(rd, 32'hA5);
    // Mailbox 0 toward local side, mailbox 1 toward PCI
    lnk(1'b1, OFS_INTERRUPT_CONTROL, 32'h3);
    lnk(1'b1, OFS_INTERRUPT_DIRECTION, 32'h2);
    lnk(1'b1, OFS_MAILBOX0, 32'h1111_2222);
    chk_bit(link.int_n, 1'b1);
    lb_owner <= 1'b0;
    pci_wr(2'h0, 4'hF, 32'hFFFF_FFFF);
    chk_bit(link.int_n, 1'b1);
    pci_wr(2'h0, 4'hE, 32'hAAAA_AA5A);
    chk_bit(link.int_n, 1'b0);
    apb(1'b0, HC_OFS_STATUS, 32'h0);
    chk_bit(st[3], 1'b1);
    pci_wr(2'h1, 4'h0, 32'h3333_4444);
    chk_bit(pci_int_n, 1'b1);
    pci_mb_sel <= 2'h0;
    repeat (2) @(posedge i_core_clk);
    chk_word(pci_mb_rdata, 32'h1111_225A);
    lb_owner <= 1'b1;
    lnk(1'b0, OFS_MAILBOX0 | 12'h004, 32'h0);
    chk_word(rd, 32'h3333_4444);
    lnk(1'b0, OFS_INTERRUPT_STATUS, 32'h0);
    chk_word(rd & 32'hF, 32'h1);
    lnk(1'b1, OFS_INTERRUPT_CONTROL, 32'h2);
    chk_bit(link.int_n, 1'b1);
    lnk(1'b1, OFS_INTERRUPT_CONTROL, 32'h3);
    chk_bit(link.int_n, 1'b0);
    lnk(1'b1, OFS_INTERRUPT_STATUS, 32'h1);
    chk_bit(link.int_n, 1'b1);
    lnk(1'b1, OFS_MAILBOX0 | 12'h004, 32'h5555);
    chk_bit(pci_int_n, 1'b0);
    chk_bit(link.int_n, 1'b1);
    lb_owner <= 1'b0;
    pci_stat_clr <= 4'h2;
    @(posedge i_core_clk);
    pci_stat_clr <= 4'h0;
    repeat (4) @(posedge i_core_clk);
    chk_bit(pci_int_n, 1'b1);
    conclude();
  end
endmodule // config_cycle_gen_and_mailboxes_test
